// *** rtl/gioss_pkg.sv ***
package gioss_pkg;
  // instruction field layout
  localparam int GIOSS_CLASS_HI = 15;
  localparam int GIOSS_CLASS_LO = 14;
  localparam int GIOSS_OP_HI = 13;
  localparam int GIOSS_OP_LO = 8;
  localparam int GIOSS_REG_BIT = 9;
  localparam int GIOSS_DEV_HI = 7;
  localparam int GIOSS_DEV_LO = 3;
  localparam int GIOSS_FN_HI = 2;
  localparam int GIOSS_FN_LO = 0;
  localparam int GIOSS_BYTE_HI = 7;
  localparam logic [1:0] GIOSS_CLASS_IO = 2'h1;
  // upper opcode byte values (register bit cleared, except GIOSS_OP_SELX and GIOSS_OP_RDBM)
  localparam logic [7:0] GIOSS_OP_SKIPF = 8'h48;
  localparam logic [7:0] GIOSS_OP_SEL = 8'h40;
  localparam logic [7:0] GIOSS_OP_SELA = 8'h44;
  localparam logic [7:0] GIOSS_OP_SELX = 8'h46;
  localparam logic [7:0] GIOSS_OP_INW = 8'h58;
  localparam logic [7:0] GIOSS_OP_INB = 8'h78;
  localparam logic [7:0] GIOSS_OP_INWM = 8'h5C;
  localparam logic [7:0] GIOSS_OP_INBM = 8'h7C;
  localparam logic [7:0] GIOSS_OP_RDW = 8'h59;
  localparam logic [7:0] GIOSS_OP_RDB = 8'h79;
  localparam logic [7:0] GIOSS_OP_RDWM = 8'h5D;
  localparam logic [7:0] GIOSS_OP_RDBM = 8'h7F;
  localparam logic [7:0] GIOSS_REG_MASK = 8'h02;
  localparam logic [15:0] GIOSS_PC_ONE = 16'h0001;
  localparam logic [15:0] GIOSS_PC_TWO = 16'h0002;
  localparam logic [15:0] GIOSS_ZERO16 = 16'h0000;
  // last wait count, lets the response clear the synchroniser
  localparam logic [1:0] GIOSS_WAIT_LAST = 2'h2;

  // instruction type signalled to the interface
  typedef enum logic [1:0] {
    GIOSS_T_NONE,
    GIOSS_T_SENSE,
    GIOSS_T_SELECT,
    GIOSS_T_INPUT
  } gioss_type_t;

  // bus toward the peripheral interfaces
  typedef struct packed {
    logic strobe;
    gioss_type_t itype;
    logic [4:0] dev;
    logic [2:0] fn;
    logic data_oe;
    logic [15:0] data;
  } gioss_bus_t;

  // result back to the sequencer
  typedef struct packed {
    logic done;
    logic wr_a;
    logic wr_x;
    logic [15:0] wdata;
    logic [15:0] pc_inc;
    logic take_irq;
    logic illegal;
  } gioss_res_t;
endpackage

// *** rtl/gioss_exec.sv ***
// Summary of operation
// (RULE1) skip-if-false: false adds two, true one
// (RULE2) select sends function, select signal, nothing changes
// (RULE3) select-present also drives A or X out
// (RULE4) peripheral decodes address, function, type, data
// (RULE5) byte input loads low half, keeps high
// (RULE6) unconditional input reads without any sense test
// (RULE7) conditional input waits for true response
// (RULE8) interrupt taken after each failed test; the code takes it only while irq_pending is set, else it retries
// (RULE9) masked word input ands all sixteen bits
// (RULE10) masked byte input ands low half only
// (RULE11) word input replaces whole A or X
// (RULE12) byte input writes low half of A/X
// (RULE13) masked word input ands into A or X
// (RULE14) masked byte ands bits zero to seven
// (RULE15) peripheral picks data source by function
// (RULE16) fields: class, operation, device, function code
// (RULE17) bit nine picks accumulator or index
// (RULE18) instruction type signalled to the interface
// (RULE19) single response line sampled once per test
module gioss_exec (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // instruction issue from the sequencer
  input wire logic start,
  input wire logic [15:0] instr,
  input wire logic [15:0] accum,
  input wire logic [15:0] index,
  input wire logic irq_pending,
  // peripheral side pins
  input wire logic resp_pin,
  input wire logic [15:0] data_in_pin,
  output gioss_pkg::gioss_bus_t bus,
  // result to the sequencer
  output gioss_pkg::gioss_res_t res,
  output logic busy
);
  import gioss_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] resp_sync_q, resp_sync_d; // stage 0 feeds stage 1 only
  logic [15:0] din_s1_q, din_s1_d;
  logic [15:0] din_s2_q, din_s2_d;

  // two-stage capture of outside inputs
  always_comb begin
    resp_sync_d = {resp_sync_q[0], resp_pin};
    din_s1_d = data_in_pin;
    din_s2_d = din_s1_q;
  end

  // register the synchronisers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resp_sync_q <= 2'h0;
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
    end else begin
      resp_sync_q <= resp_sync_d;
      din_s1_q <= din_s1_d;
      din_s2_q <= din_s2_d;
    end
  end

  logic resp_s; // synchronised response
  logic [15:0] din_s; // synchronised data bus
  assign resp_s = resp_sync_q[1];
  assign din_s = din_s2_q;

  ////////////////////////////////////////////////////////////////////
  // decode of the held instruction
  typedef enum logic [1:0] {
    GIOSS_S_IDLE,
    GIOSS_S_PRESENT,
    GIOSS_S_WAIT,
    GIOSS_S_SAMPLE
  } gioss_state_t;

  gioss_state_t st_q, st_d;
  logic [15:0] ir_q, ir_d; // held instruction
  logic [15:0] opnd_q, opnd_d; // captured A or X
  logic [1:0] wait_q, wait_d; // lets the sync chain settle
  gioss_bus_t bus_q, bus_d;
  gioss_res_t res_q, res_d;

  logic [7:0] op_hi; // upper byte with register bit
  logic [7:0] op_base; // upper byte, register bit cleared
  logic use_x; // index selected
  logic is_io;
  logic is_skipf, is_sel, is_sep, is_inw, is_inb, is_inwm, is_inbm;
  logic is_rdw, is_rdb, is_rdwm, is_rdbm;
  logic is_input, is_cond, is_byte, is_mask;

  // split the instruction into class, operation and register (RULE16)
  always_comb begin
    op_hi = ir_q[GIOSS_CLASS_HI:GIOSS_OP_LO];
    op_base = op_hi & ~GIOSS_REG_MASK;
    use_x = ir_q[GIOSS_REG_BIT]; // RULE17
    is_io = (ir_q[GIOSS_CLASS_HI:GIOSS_CLASS_LO] == GIOSS_CLASS_IO);
    is_skipf = (op_hi == GIOSS_OP_SKIPF);
    is_sel = (op_hi == GIOSS_OP_SEL);
    is_sep = (op_hi == GIOSS_OP_SELA) || (op_hi == GIOSS_OP_SELX);
    is_inw = (op_base == GIOSS_OP_INW);
    is_inb = (op_base == GIOSS_OP_INB);
    is_inwm = (op_base == GIOSS_OP_INWM);
    is_inbm = (op_base == GIOSS_OP_INBM);
    is_rdw = (op_base == GIOSS_OP_RDW);
    is_rdb = (op_base == GIOSS_OP_RDB);
    is_rdwm = (op_base == GIOSS_OP_RDWM);
    // conditional masked byte read keeps bit nine as register choice
    is_rdbm = ((op_hi | GIOSS_REG_MASK) == GIOSS_OP_RDBM) &&
              (op_base != GIOSS_OP_INBM);
    is_cond = is_rdw || is_rdb || is_rdwm || is_rdbm;
    is_input = is_inw || is_inb || is_inwm || is_inbm || is_cond;
    is_byte = is_inb || is_inbm || is_rdb || is_rdbm;
    is_mask = is_inwm || is_inbm || is_rdwm || is_rdbm;
  end

  ////////////////////////////////////////////////////////////////////
  // merge of input data into the receiving register
  logic [15:0] merged; // value written to A or X
  always_comb begin
    merged = opnd_q;
    if (is_byte) begin
      // high half is kept in every byte form
      if (is_mask) begin
        merged[GIOSS_BYTE_HI:0] =
          din_s[GIOSS_BYTE_HI:0] & opnd_q[GIOSS_BYTE_HI:0]; // RULE10 RULE14
      end else begin
        merged[GIOSS_BYTE_HI:0] = din_s[GIOSS_BYTE_HI:0]; // RULE5 RULE12
      end
    end else if (is_mask) begin
      merged = din_s & opnd_q; // RULE9 RULE13
    end else begin
      merged = din_s; // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer: present, let the response settle, sample once
  always_comb begin
    st_d = st_q;
    ir_d = ir_q;
    opnd_d = opnd_q;
    wait_d = wait_q;
    bus_d = bus_q;
    res_d = '0;
    case (st_q)
      GIOSS_S_IDLE: begin
        bus_d = '0;
        if (start) begin
          ir_d = instr;
          opnd_d = instr[GIOSS_REG_BIT] ? index : accum;
          st_d = GIOSS_S_PRESENT;
        end
      end
      GIOSS_S_PRESENT: begin
        if (!is_io || !(is_skipf || is_sel || is_sep || is_input)) begin
          // outside this block: hand back untouched
          res_d.done = 1'b1;
          res_d.illegal = 1'b1;
          res_d.pc_inc = GIOSS_PC_ONE;
          st_d = GIOSS_S_IDLE;
        end else begin
          bus_d.strobe = 1'b1;
          bus_d.dev = ir_q[GIOSS_DEV_HI:GIOSS_DEV_LO];
          bus_d.fn = ir_q[GIOSS_FN_HI:GIOSS_FN_LO];
          // type tells the interface how to read the function (RULE18)
          if (is_skipf) begin
            bus_d.itype = GIOSS_T_SENSE;
          end else if (is_input) begin
            bus_d.itype = GIOSS_T_INPUT;
          end else begin
            bus_d.itype = GIOSS_T_SELECT; // RULE2
          end
          bus_d.data_oe = is_sep; // RULE3
          bus_d.data = is_sep ? opnd_q : GIOSS_ZERO16; // RULE3
          wait_d = 2'h0;
          st_d = GIOSS_S_WAIT;
        end
      end
      GIOSS_S_WAIT: begin
        // three cycles so the response passes the synchroniser
        wait_d = wait_q + 2'h1;
        if (wait_q == GIOSS_WAIT_LAST) begin
          st_d = GIOSS_S_SAMPLE;
        end
      end
      GIOSS_S_SAMPLE: begin
        bus_d = '0;
        st_d = GIOSS_S_IDLE;
        res_d.done = 1'b1;
        res_d.pc_inc = GIOSS_PC_ONE;
        if (is_skipf) begin
          res_d.pc_inc = resp_s ? GIOSS_PC_ONE : GIOSS_PC_TWO; // RULE1 RULE19
        end else if (is_input && (!is_cond || resp_s)) begin
          // unconditional forms never look at the response (RULE6)
          res_d.wr_a = !use_x; // RULE17
          res_d.wr_x = use_x;
          res_d.wdata = merged;
        end else if (is_cond) begin
          // false response: retry, or yield to an interrupt (RULE7 RULE8)
          if (irq_pending) begin
            res_d.done = 1'b1;
            res_d.take_irq = 1'b1;
            res_d.pc_inc = GIOSS_ZERO16; // resumes same instruction
          end else begin
            res_d.done = 1'b0;
            bus_d = bus_q;
            wait_d = 2'h0;
            st_d = GIOSS_S_WAIT; // RULE7
          end
        end
      end
      default: begin
        st_d = GIOSS_S_IDLE;
        bus_d = '0;
      end
    endcase
  end

  // register sequencer state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= GIOSS_S_IDLE;
      ir_q <= 16'h0000;
      opnd_q <= 16'h0000;
      wait_q <= 2'h0;
      bus_q <= '0;
      res_q <= '0;
    end else begin
      st_q <= st_d;
      ir_q <= ir_d;
      opnd_q <= opnd_d;
      wait_q <= wait_d;
      bus_q <= bus_d;
      res_q <= res_d;
    end
  end

  assign bus = bus_q;
  assign res = res_q;
  assign busy = (st_q != GIOSS_S_IDLE);

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_skip_false;
    @(posedge clk_sys) disable iff (rst)
      (st_q == GIOSS_S_SAMPLE && is_skipf && !resp_s) |=>
        (res.done && res.pc_inc == GIOSS_PC_TWO);
  endproperty
  a_skip_false: assert property (p_skip_false) // RULE1
    else $error("skip on false did not add two");

  property p_skip_true;
    @(posedge clk_sys) disable iff (rst)
      (st_q == GIOSS_S_SAMPLE && is_skipf && resp_s) |=>
        (res.pc_inc == GIOSS_PC_ONE && !res.wr_a && !res.wr_x);
  endproperty
  a_skip_true: assert property (p_skip_true) // RULE1
    else $error("skip on true did not add one");

  property p_select_nowrite;
    @(posedge clk_sys) disable iff (rst)
      (st_q == GIOSS_S_SAMPLE && (is_sel || is_sep)) |=>
        (res.done && !res.wr_a && !res.wr_x);
  endproperty
  a_select_nowrite: assert property (p_select_nowrite) // RULE2
    else $error("select wrote a register");

  property p_present_data;
    @(posedge clk_sys) disable iff (rst)
      (bus.strobe && bus.itype == GIOSS_T_SELECT && is_sep) |->
        (bus.data_oe && bus.data == opnd_q);
  endproperty
  a_present_data: assert property (p_present_data) // RULE3
    else $error("present did not drive operand");

  property p_byte_high;
    @(posedge clk_sys) disable iff (rst)
      (st_q == GIOSS_S_SAMPLE && is_byte) |=>
        ((res.wr_a || res.wr_x) ->
          res.wdata[15:8] == $past(opnd_q[15:8]));
  endproperty
  a_byte_high: assert property (p_byte_high) // RULE5
    else $error("byte input changed high half");

  property p_uncond_writes;
    @(posedge clk_sys) disable iff (rst)
      (st_q == GIOSS_S_SAMPLE && is_input && !is_cond) |=>
        (res.wr_a ^ res.wr_x);
  endproperty
  a_uncond_writes: assert property (p_uncond_writes) // RULE6
    else $error("unconditional input did not write");

  sequence s_cond_fail;
    st_q == GIOSS_S_SAMPLE && is_cond && !resp_s && !irq_pending;
  endsequence
  property p_cond_retry;
    @(posedge clk_sys) disable iff (rst)
      s_cond_fail |=> (st_q == GIOSS_S_WAIT && !res.done) [*3];
  endproperty
  a_cond_retry: assert property (p_cond_retry) // RULE7
    else $error("conditional input did not retry");

  property p_cond_irq;
    @(posedge clk_sys) disable iff (rst)
      (st_q == GIOSS_S_SAMPLE && is_cond && !resp_s && irq_pending) |=>
        (res.take_irq && res.pc_inc == GIOSS_ZERO16 && !res.wr_a);
  endproperty
  a_cond_irq: assert property (p_cond_irq) // RULE8
    else $error("interrupt not taken after failed test");

  property p_mask_word;
    @(posedge clk_sys) disable iff (rst)
      (st_q == GIOSS_S_SAMPLE && is_inwm) |=>
        (res.wdata == ($past(din_s) & $past(opnd_q)));
  endproperty
  a_mask_word: assert property (p_mask_word) // RULE9
    else $error("masked word result wrong");

  property p_reg_pick;
    @(posedge clk_sys) disable iff (rst)
      (st_q == GIOSS_S_SAMPLE && is_input && !is_cond) |=>
        (res.wr_x == $past(use_x));
  endproperty
  a_reg_pick: assert property (p_reg_pick) // RULE17
    else $error("wrong receiving register");
endmodule

// *** testbench/gioss_periph_model.sv ***
// peripheral interface at the far side of the i/o bus
module gioss_periph_model
  import gioss_pkg::*;
#(
  parameter logic [4:0] ADDR = 5'h0A // decoded device address
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus from the processor
  input wire gioss_pkg::gioss_bus_t bus,
  // scenario controls
  input wire logic resp_true,
  input wire logic [15:0] src_word,
  // pins back to the processor
  output logic resp_pin,
  output logic [15:0] data_in_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  import gioss_pkg::*;
  logic drive; // this device answers now
  logic [15:0] src_sel; // source picked by function
  logic [15:0] last_data_q; // last value put on the bus
  logic last_resp_q; // last response level
  // function bit zero picks the inverted source
  assign src_sel = bus.fn[0] ? ~src_word : src_word;
  // only a strobed sense or input to our address gets an answer
  assign drive = bus.strobe && bus.dev == ADDR &&
                 bus.itype != GIOSS_T_SELECT;
  // released lines show the inverse, so stale values cannot pass
  assign resp_pin = drive ? resp_true : ~last_resp_q;
  assign data_in_pin = drive ? src_sel : ~last_data_q;
  ////////////////////////////////////////////////////////////////////
  // remember what was last driven
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_data_q <= 16'h0000;
      last_resp_q <= 1'b0;
    end else if (drive) begin
      last_data_q <= src_sel;
      last_resp_q <= resp_true;
    end
  end
endmodule

// *** testbench/testbench.sv ***
module testbench
  import gioss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  import gioss_pkg::*;
  // clock, reset and issue side
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [15:0] accum = 16'h1234;
  logic [15:0] index = 16'hABCD;
  logic irq_pending = 1'b0;
  // far side controls and pins
  logic resp_true = 1'b0;
  logic [15:0] src_word = 16'hC35A;
  logic resp_pin;
  logic [15:0] data_in_pin;
  gioss_bus_t bus;
  gioss_res_t res;
  logic busy;
  // bench bookkeeping
  gioss_bus_t seen_bus;
  gioss_res_t got;
  logic strobe_seen;
  logic got_done;
  int n_fail = 0;
  int checks_done = 0;
  localparam logic [7:0] DEV_FN = 8'h53; // device 0A, function 3
  logic [7:0] sel_ops [3] = '{GIOSS_OP_SEL, GIOSS_OP_SELA, GIOSS_OP_SELX};
  // unconditional forms first, then the conditional ones
  logic [7:0] in_ops [16] = '{8'h58, 8'h5A, 8'h78, 8'h7A,
                              8'h5C, 8'h5E, 8'h7C, 8'h7E,
                              8'h59, 8'h5B, 8'h79, 8'h7B,
                              8'h5D, 8'h5F, 8'h7D, 8'h7F};
  gioss_exec dut_u (.clk_sys(clk_sys), .rst(rst), .start(start),
    .instr(instr), .accum(accum), .index(index),
    .irq_pending(irq_pending), .resp_pin(resp_pin),
    .data_in_pin(data_in_pin), .bus(bus), .res(res), .busy(busy));
  gioss_periph_model #(.ADDR(5'h0A)) model_u (.clk_sys(clk_sys),
    .rst(rst), .bus(bus), .resp_true(resp_true), .src_word(src_word),
    .resp_pin(resp_pin), .data_in_pin(data_in_pin));
  // 25 mhz clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // compare with case equality so unknowns fail
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // bounded wait for the result pulse, catching the bus on the way
  task automatic wait_done(input logic must, input int lim);
    got_done = 1'b0;
    for (int k = 0; k < lim && !got_done; k++) begin
      @(negedge clk_sys);
      if (bus.strobe === 1'b1) begin
        seen_bus = bus;
        strobe_seen = 1'b1;
      end
      if (res.done === 1'b1) begin
        got = res;
        got_done = 1'b1;
      end
    end
    if (must && !got_done) begin
      n_fail++;
      $display("mismatch at %0t: no completion", $time);
      finish_test();
    end
  endtask
  // one start cycle while idle, then wait
  task automatic issue(input logic [15:0] op, input logic must,
                       input int lim);
    @(negedge clk_sys);
    instr = op;
    start = 1'b1;
    strobe_seen = 1'b0;
    @(negedge clk_sys);
    start = 1'b0;
    wait_done(must, lim);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_sense();
    for (int r = 0; r < 2; r++) begin
      resp_true = r[0];
      issue({GIOSS_OP_SKIPF, DEV_FN}, 1'b1, 12);
      check(got.pc_inc, r[0] ? GIOSS_PC_ONE : GIOSS_PC_TWO);
      check(16'(seen_bus.itype), 16'(GIOSS_T_SENSE));
      check(16'({got.wr_a, got.wr_x}), 16'h0000);
    end
  endtask
  task automatic t_select();
    for (int i = 0; i < 3; i++) begin
      issue({sel_ops[i], DEV_FN}, 1'b1, 12);
      check(16'(seen_bus.itype), 16'(GIOSS_T_SELECT));
      check(16'({seen_bus.dev, seen_bus.fn}), 16'(DEV_FN));
      check(16'(seen_bus.data_oe), 16'(i != 0));
      if (i != 0)
        check(seen_bus.data, sel_ops[i][1] ? index : accum);
      else
        check(seen_bus.data, 16'h0000);
      check(16'({got.wr_a, got.wr_x}), 16'h0000);
    end
  endtask
  // every input form: unconditional ones see a false response,
  // conditional ones a true response, so all of them transfer
  task automatic t_input();
    logic [15:0] opnd;
    logic [15:0] din;
    logic [15:0] exp;
    for (int i = 0; i < 16; i++) begin
      resp_true = in_ops[i][0];
      opnd = in_ops[i][1] ? index : accum;
      din = i[0] ? ~src_word : src_word;
      exp = in_ops[i][2] ? (opnd & din) : din;
      if (in_ops[i][5])
        exp = {opnd[15:8], exp[7:0]};
      issue({in_ops[i], 5'h0A, i[2:0]}, 1'b1, 12);
      check(got.wdata, exp);
      check(16'({got.wr_a, got.wr_x}),
            in_ops[i][1] ? 16'h0001 : 16'h0002);
      check(16'(seen_bus.itype), 16'(GIOSS_T_INPUT));
      check(16'({seen_bus.dev, seen_bus.fn}), {8'h00, 5'h0A, i[2:0]});
      check(got.pc_inc, GIOSS_PC_ONE);
    end
  endtask
  // conditional read hangs until the response turns true
  task automatic t_cond();
    resp_true = 1'b0;
    issue({8'h59, DEV_FN}, 1'b0, 20);
    check(16'({got_done, busy}), 16'h0001);
    resp_true = 1'b1;
    wait_done(1'b1, 20);
    check(got.wdata, ~src_word);
    check(16'({got.wr_a, got.wr_x}), 16'h0002);
  endtask
  task automatic t_irq();
    resp_true = 1'b0;
    irq_pending = 1'b1;
    issue({8'h5B, DEV_FN}, 1'b1, 12);
    irq_pending = 1'b0;
    check(16'(got.take_irq), 16'h0001);
    check(got.pc_inc, GIOSS_ZERO16);
    check(16'({got.wr_a, got.wr_x}), 16'h0000);
  endtask
  // outside the i/o class: refused, no bus cycle
  task automatic t_illegal();
    issue(16'h0000, 1'b1, 12);
    check(16'({got.illegal, strobe_seen}), 16'h0002);
    check(got.pc_inc, GIOSS_PC_ONE);
  endtask
  ////////////////////////////////////////////////////////////////////
  // reset, then every scenario in turn
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    t_sense();
    t_select();
    t_input();
    t_cond();
    t_irq();
    t_illegal();
    finish_test();
  end
endmodule
